// ===== verilog/adcdp_core.v
`timescale 1ns/10ps
`include "adcdp_defs.vh"
// How it works
// - each channel filters the modulator bits with a sinc3 decimator of ratio N
// - a step at the input needs three output periods to show fully
// - after start rises, first result waits for the settling interval
// - source pin 0 takes external clock; 1 runs oscillator, pin out if enabled
// - external clock 512 kHz or 2.048 MHz chosen by divider bit 6
// - modulator clock is 128 kHz whichever external clock is used
// - divider select resets to the 512 kHz setting
// - each result is a 16-bit two's-complement word sent msb first
// - results saturate at 7fff and 8000 instead of wrapping
// - one step is vref over 2^15-1, zero gives code zero
// - ready output goes low when a new result is available
// - ready asserts on each conversion regardless of chip select
// - select high resets the shifter, ignores data, floats output; a falling clock still releases ready
// - a truncated frame is only cleared by raising select
// - reference buffer starts powered down after reset
// - one data-rate field sets the ratio of both channels
// - device clock divided by 4 or 16 forms the modulator clock
module adcdp_core (
    // clock and reset
    input  wire                    clk,
    input  wire                    rst_n,
    // clock source control
    input  wire                    clock_source_select_pin,
    input  wire                    clock_out_enable,
    input  wire                    dev_clk_in,
    output reg                     dev_clk_out,
    output wire                    dev_clk_oe,
    // configuration
    input  wire                    clk_div_wr,
    input  wire                    clk_div_wdata,
    output wire [7:0]              lead_off_status_register,
    input  wire [`ADCDP_DR_W-1:0]  data_rate_field,
    input  wire                    ref_buf_wr,
    input  wire                    ref_buf_wdata,
    output reg                     reference_buffer_power,
    input  wire                    start,
    // modulator bitstreams
    input  wire                    mod_bit_ch1,
    input  wire                    mod_bit_ch2,
    output wire                    mod_sample_en,
    // serial port, inputs synchronous to clk
    input  wire                    cs_n,
    input  wire                    sclk,
    input  wire                    din,
    output reg                     dout,
    output wire                    dout_oe,
    output reg                     conversion_ready_n,
    // buffered result stream
    output wire                    res_valid,
    input  wire                    res_ready,
    output wire [31:0]             res_data,
    output wire                    res_overrun
);
    // ----------------------------------------
    // clock source and modulator rate
    // ----------------------------------------
    reg        clk_div_q;
    reg  [7:0] osc_cnt_q;
    reg        ext_clk_q;
    reg  [7:0] dev_cnt_q;
    wire       dev_tick;
    wire       ext_rise;
    wire       use_ext;
    wire [7:0] div_ratio;

    assign use_ext    = (clock_source_select_pin == `ADCDP_SRC_EXTERNAL);
    assign dev_clk_oe = !use_ext && clock_out_enable;
    assign ext_rise   = dev_clk_in && !ext_clk_q;
    // internal oscillator is modelled as a divider of clk
    assign dev_tick   = use_ext ? ext_rise
                      : (osc_cnt_q == `ADCDP_OSC_HALF - 8'h01) && !dev_clk_out;
    // 512 kHz / 4 or 2.048 MHz / 16 both give 128 kHz
    assign div_ratio  = clk_div_q ? `ADCDP_DIV_FAST : `ADCDP_DIV_SLOW;
    // at or above, so a ratio change mid-count cannot stall the strobe
    assign mod_sample_en = dev_tick && (dev_cnt_q >= div_ratio - 8'h01);
    assign lead_off_status_register =
        {1'b0, clk_div_q, 6'h00};

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            clk_div_q   <= `ADCDP_CLK_DIV_RST;
            reference_buffer_power <= `ADCDP_REFBUF_RST;
            osc_cnt_q   <= 8'h00;
            dev_clk_out <= 1'b0;
            ext_clk_q   <= 1'b0;
            dev_cnt_q   <= 8'h00;
        end
        else
        begin
            if (clk_div_wr)
            begin
                clk_div_q <= clk_div_wdata;
            end
            if (ref_buf_wr)
            begin
                reference_buffer_power <= ref_buf_wdata;
            end
            ext_clk_q <= dev_clk_in;
            if (osc_cnt_q == `ADCDP_OSC_HALF - 8'h01)
            begin
                osc_cnt_q   <= 8'h00;
                dev_clk_out <= !dev_clk_out;
            end
            else
            begin
                osc_cnt_q <= osc_cnt_q + 8'h01;
            end
            if (dev_tick)
            begin
                dev_cnt_q <= mod_sample_en ? 8'h00 : dev_cnt_q + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // decimation control and settling
    // ----------------------------------------
    reg  [10:0] dec_cnt_q;
    reg  [12:0] settle_q;
    reg         start_q;
    reg  [1:0]  skip_q;
    wire [4:0]  dec_log2;
    wire [10:0] dec_n;
    wire        dec_tick;
    wire        start_rise;
    wire        result_tick;
    wire [15:0] res_ch1;
    wire [15:0] res_ch2;

    // ratio 2^(11-dr), from 2048 down to 16; shared by both channels
    function [4:0] ratio_log2;
        input [`ADCDP_DR_W-1:0] dr;
        begin
            ratio_log2 = 5'd11 - {2'b00, dr};
        end
    endfunction

    assign dec_log2    = ratio_log2(data_rate_field);
    assign dec_n       = 11'h7ff >> (5'd11 - dec_log2);
    // a halted converter issues no result
    assign dec_tick    = mod_sample_en && start && (dec_cnt_q == dec_n);
    assign start_rise  = start && !start_q;
    // first word after start is held back for the filter's three stages
    assign result_tick = dec_tick && (skip_q == 2'd0) && (settle_q == 13'h0);

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            dec_cnt_q <= 11'h000;
            settle_q  <= 13'h0000;
            start_q   <= 1'b0;
            skip_q    <= 2'd0;
        end
        else
        begin
            start_q <= start;
            if (start_rise)
            begin
                dec_cnt_q <= 11'h000;
                // combs need three full periods of fresh data
                skip_q    <= `ADCDP_STEP_PERIODS;
                settle_q  <= 13'h0004;
            end
            else if (mod_sample_en && start)
            begin
                dec_cnt_q <= dec_tick ? 11'h000 : dec_cnt_q + 11'h001;
                if (settle_q != 13'h0)
                begin
                    settle_q <= settle_q - 13'h0001;
                end
                if (dec_tick && skip_q != 2'd0)
                begin
                    skip_q <= skip_q - 2'd1;
                end
            end
        end
    end

    adcdp_sinc3 u_ch1 (
        .clk      (clk),
        .rst_n    (rst_n),
        .mod_en   (mod_sample_en && start),
        .mod_bit  (mod_bit_ch1),
        .clear    (start_rise),
        .dec_tick (dec_tick),
        .dec_log2 (dec_log2),
        .result_q (res_ch1)
    );

    adcdp_sinc3 u_ch2 (
        .clk      (clk),
        .rst_n    (rst_n),
        .mod_en   (mod_sample_en && start),
        .mod_bit  (mod_bit_ch2),
        .clear    (start_rise),
        .dec_tick (dec_tick),
        .dec_log2 (dec_log2),
        .result_q (res_ch2)
    );

    // ----------------------------------------
    // holding register and ready flag
    // ----------------------------------------
    reg  [31:0] hold_q;
    reg         new_q;
    reg         sclk_q;
    reg         overrun_q;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        fifo_in_ready;

    assign sclk_rise   = sclk && !sclk_q;
    assign sclk_fall   = !sclk && sclk_q;
    assign res_overrun = overrun_q;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            hold_q             <= 32'h0000_0000;
            new_q              <= 1'b0;
            conversion_ready_n <= 1'b1;
            sclk_q             <= 1'b0;
            overrun_q          <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk;
            new_q  <= result_tick;
            if (start_rise)
            begin
                conversion_ready_n <= 1'b1;
            end
            else if (new_q)
            begin
                // set wins over a coincident serial-clock clear
                hold_q             <= {res_ch1, res_ch2};
                conversion_ready_n <= 1'b0;
            end
            else if (sclk_fall)
            begin
                // released on any falling clock, select level not used
                conversion_ready_n <= 1'b1;
            end
            if (new_q && !fifo_in_ready)
            begin
                overrun_q <= 1'b1;
            end
        end
    end

    adcdp_fifo #(
        .WIDTH (32),
        .DEPTH (`ADCDP_FIFO_DEPTH),
        .AW    (`ADCDP_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (new_q),
        .in_ready  (fifo_in_ready),
        .in_data   ({res_ch1, res_ch2}),
        .out_valid (res_valid),
        .out_ready (res_ready),
        .out_data  (res_data),
        .full      (),
        .empty     ()
    );

    // ----------------------------------------
    // serial readout
    // ----------------------------------------
    reg  [4:0] bit_q;

    assign dout_oe = !cs_n;

    always @(posedge clk)
    begin
        if (!rst_n || cs_n)
        begin
            // select high clears a half-shifted frame as well
            bit_q <= 5'd0;
            dout  <= 1'b0;
        end
        else if (sclk_rise)
        begin
            // msb first, wraps to repeat the frame on extra clocks
            dout  <= hold_q[5'd31 - bit_q];
            bit_q <= bit_q + 5'd1;
        end
    end
endmodule

// ===== verilog/adcdp_defs.vh
`ifndef ADCDP_DEFS_VH
`define ADCDP_DEFS_VH

// ----------------------------------------
// clocking
// ----------------------------------------
`define ADCDP_CLK_DIV_BIT      6
`define ADCDP_CLK_DIV_RST      1'b0
`define ADCDP_DIV_SLOW         8'h04
`define ADCDP_DIV_FAST         8'h10
`define ADCDP_SRC_EXTERNAL     1'b0
`define ADCDP_OSC_HALF         8'h08

// ----------------------------------------
// decimator
// ----------------------------------------
`define ADCDP_DR_W             3
`define ADCDP_DR_RST           3'h2
`define ADCDP_ACC_W            32
`define ADCDP_STEP_PERIODS     2'd3
`define ADCDP_CODE_MAX         16'h7fff
`define ADCDP_CODE_MIN         16'h8000

// ----------------------------------------
// serial port
// ----------------------------------------
`define ADCDP_WORD_W           16
`define ADCDP_FIFO_DEPTH       16
`define ADCDP_FIFO_AW          4
`define ADCDP_REFBUF_RST       1'b0

`endif

// ===== verilog/adcdp_fifo.v
`timescale 1ns/10ps
// ----------------------------------------
// result fifo
// ----------------------------------------
module adcdp_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data,
    // state
    output wire             full,
    output wire             empty
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign full      = (cnt_q == DEPTH[AW:0]);
    assign empty     = (cnt_q == {(AW+1){1'b0}});
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;

    always @*
    begin
        out_data = mem[rd_q];
    end

    always @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ===== verilog/adcdp_sinc3.v
`timescale 1ns/10ps
`include "adcdp_defs.vh"
// ----------------------------------------
// third-order sinc decimator, one channel
// ----------------------------------------
module adcdp_sinc3 (
    // clock and reset
    input  wire                   clk,
    input  wire                   rst_n,
    // modulator side
    input  wire                   mod_en,
    input  wire                   mod_bit,
    input  wire                   clear,
    // decimation
    input  wire                   dec_tick,
    input  wire [4:0]             dec_log2,
    // result
    output reg  [`ADCDP_WORD_W-1:0] result_q
);
    reg  [`ADCDP_ACC_W-1:0] i1_q;
    reg  [`ADCDP_ACC_W-1:0] i2_q;
    reg  [`ADCDP_ACC_W-1:0] i3_q;
    reg  [`ADCDP_ACC_W-1:0] c1_q;
    reg  [`ADCDP_ACC_W-1:0] c2_q;
    reg  [`ADCDP_ACC_W-1:0] c3_q;
    wire [`ADCDP_ACC_W-1:0] d1;
    wire [`ADCDP_ACC_W-1:0] d2;
    wire [`ADCDP_ACC_W-1:0] d3;
    wire signed [`ADCDP_ACC_W-1:0] centred;
    wire signed [`ADCDP_ACC_W-1:0] scaled;
    wire [`ADCDP_ACC_W-1:0] half;
    wire [`ADCDP_ACC_W-1:0] i1_nx;
    wire [`ADCDP_ACC_W-1:0] i2_nx;

    // bitstream as +1/-1 so zero input averages to code zero
    assign i1_nx = mod_bit ? i1_q + 1'b1 : i1_q - 1'b1;
    // chained sums keep the lag to one sample, so the third
    // output after a step is fully settled
    assign i2_nx = i2_q + i1_nx;
    assign d1 = i3_q - c1_q;
    assign d2 = d1 - c2_q;
    assign d3 = d2 - c3_q;
    // full gain is N^3, keep 16 bits by shifting 3*log2(N)-15
    assign half    = {`ADCDP_ACC_W{1'b0}};
    assign centred = d3;
    assign scaled  = centred >>> (3 * dec_log2 - 5'd15);

    function [`ADCDP_WORD_W-1:0] clip16;
        input signed [`ADCDP_ACC_W-1:0] v;
        begin
            if (v > $signed({{17{1'b0}}, 15'h7fff}))
                clip16 = `ADCDP_CODE_MAX;
            else if (v < -$signed({{17{1'b0}}, 15'h7fff}))
                clip16 = `ADCDP_CODE_MIN;
            else
                clip16 = v[`ADCDP_WORD_W-1:0];
        end
    endfunction

    always @(posedge clk)
    begin
        if (!rst_n || clear)
        begin
            i1_q     <= half;
            i2_q     <= half;
            i3_q     <= half;
            c1_q     <= half;
            c2_q     <= half;
            c3_q     <= half;
            result_q <= 16'h0000;
        end
        else
        begin
            if (mod_en)
            begin
                // integrators at the modulator rate
                i1_q <= i1_nx;
                i2_q <= i2_nx;
                i3_q <= i3_q + i2_nx;
            end
            if (dec_tick)
            begin
                // combs at the output rate
                c1_q     <= i3_q;
                c2_q     <= d1;
                c3_q     <= d2;
                result_q <= clip16(scaled);
            end
        end
    end
endmodule

// ===== testbench/adcdp_core_sva.sv
`timescale 1ns/10ps
// ----------------------------------------
// port checker for the converter core
// ----------------------------------------
module adcdp_core_sva (
    // clock and reset
    input wire       clk,
    input wire       rst_n,
    // clock source and configuration
    input wire       clock_source_select_pin,
    input wire       clock_out_enable,
    input wire       dev_clk_oe,
    input wire       clk_div_wr,
    input wire       clk_div_wdata,
    input wire [7:0] lead_off_status_register,
    input wire       ref_buf_wr,
    input wire       ref_buf_wdata,
    input wire       reference_buffer_power,
    input wire       start,
    input wire       mod_sample_en,
    // serial port and results
    input wire       cs_n,
    input wire       sclk,
    input wire       dout,
    input wire       dout_oe,
    input wire       conversion_ready_n,
    input wire       res_valid
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_clk_pin;
        dev_clk_oe == (clock_source_select_pin && clock_out_enable);
    endproperty
    a_clk_pin: assert property (p_clk_pin)
        else $error("clock pin drive wrong");
    property p_div_take;
        clk_div_wr |=> lead_off_status_register[6] == $past(clk_div_wdata);
    endproperty
    a_div_take: assert property (p_div_take)
        else $error("divider select not written");
    property p_div_keep;
        !clk_div_wr |=> $stable(lead_off_status_register);
    endproperty
    a_div_keep: assert property (p_div_keep)
        else $error("divider select changed unasked");
    property p_ref_take;
        ref_buf_wr |=> reference_buffer_power == $past(ref_buf_wdata);
    endproperty
    a_ref_take: assert property (p_ref_take)
        else $error("reference buffer bit not written");
    property p_port_off;
        dout_oe == !cs_n;
    endproperty
    a_port_off: assert property (p_port_off)
        else $error("data output enable wrong");
    property p_dout_quiet;
        cs_n [*2] |-> !dout;
    endproperty
    a_dout_quiet: assert property (p_dout_quiet)
        else $error("data output moves while deselected");
    property p_ready_push;
        $fell(conversion_ready_n) |-> res_valid;
    endproperty
    a_ready_push: assert property (p_ready_push)
        else $error("ready fell without a stored result");
    property p_ready_start;
        $fell(conversion_ready_n) |-> $past(start);
    endproperty
    a_ready_start: assert property (p_ready_start)
        else $error("ready fell while halted");
    property p_ready_clear;
        $fell(sclk) && !conversion_ready_n |-> ##[1:3] conversion_ready_n;
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("ready not released by serial clock");
    property p_sample_pulse;
        mod_sample_en |=> !mod_sample_en;
    endproperty
    a_sample_pulse: assert property (p_sample_pulse)
        else $error("modulator strobe too long");
endmodule

bind adcdp_core adcdp_core_sva i_adcdp_core_sva (
    .clk, .rst_n, .clock_source_select_pin, .clock_out_enable, .dev_clk_oe,
    .clk_div_wr, .clk_div_wdata, .lead_off_status_register, .ref_buf_wr,
    .ref_buf_wdata, .reference_buffer_power, .start, .mod_sample_en, .cs_n,
    .sclk, .dout, .dout_oe, .conversion_ready_n, .res_valid
);

// ===== testbench/adcdp_host.sv
`timescale 1ns/10ps
// ----------------------------------------
// host acting as serial-port master
// ----------------------------------------
module adcdp_host (
    // clock
    input  wire  clk,
    // serial port
    output logic cs_n,
    output logic sclk,
    output logic din,
    input  wire  dout,
    input  wire  dout_oe
);
    // sclk half period in system clocks, slower than the device clock
    localparam int HALF = 4;

    initial
    begin
        cs_n = 1'h1;
        sclk = 1'h0;
        din  = 1'h0;
    end

    // raising select clears a cut frame, but this task always clocks all 32
    task automatic read_frame(output logic [31:0] w);
        @(posedge clk);
        #1 cs_n = 1'h0;
        repeat (32)
        begin
            repeat (HALF) @(posedge clk);
            #1 sclk = 1'h1;
            repeat (HALF) @(posedge clk);
            w = {w[30:0], dout & dout_oe};
            #1 sclk = 1'h0;
        end
        // four device clocks of four system clocks before deselect
        repeat (16) @(posedge clk);
        #1 cs_n = 1'h1;
    endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk, rst_n, clock_source_select_pin, clock_out_enable;
    logic        ext_clk, clk_div_wr, clk_div_wdata, ref_buf_wr;
    logic        ref_buf_wdata, start, mod_bit_ch1, mod_bit_ch2, res_ready;
    logic [2:0]  data_rate_field;
    wire         cs_n, sclk, din, dout, dout_oe, dev_clk_out, dev_clk_oe;
    wire         reference_buffer_power, mod_sample_en, conversion_ready_n;
    wire         res_valid, res_overrun, dev_clk_in;
    wire  [7:0]  lead_off_status_register;
    wire  [31:0] res_data;
    logic [31:0] w;
    int          mismatches, checked, cycles, n, k, g, half;

    // the clock pin carries whichever party drives it
    assign dev_clk_in = dev_clk_oe ? dev_clk_out : ext_clk;

    adcdp_core i_adcdp_core (
        .clk, .rst_n, .clock_source_select_pin, .clock_out_enable,
        .dev_clk_in, .dev_clk_out, .dev_clk_oe, .clk_div_wr, .clk_div_wdata,
        .lead_off_status_register, .data_rate_field, .ref_buf_wr,
        .ref_buf_wdata, .reference_buffer_power, .start, .mod_bit_ch1,
        .mod_bit_ch2, .mod_sample_en, .cs_n, .sclk, .din, .dout, .dout_oe,
        .conversion_ready_n, .res_valid, .res_ready, .res_data, .res_overrun
    );
    adcdp_host i_adcdp_host (.clk, .cs_n, .sclk, .din, .dout, .dout_oe);

    // ----------------------------------------
    // clocks and run limit
    // ----------------------------------------
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        ext_clk = 1'h0;
        forever
        begin
            repeat (half) @(posedge clk);
            #1 ext_clk = ~ext_clk;
        end
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            results();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic set_div(input logic b);
        @(posedge clk);
        #1 clk_div_wr = 1'h1;
        clk_div_wdata = b;
        @(posedge clk);
        #1 clk_div_wr = 1'h0;
        chk("divider select", {25'h0, b, 6'h0}, lead_off_status_register);
        k = 0;
        do begin @(posedge clk); k++; end
        while (mod_sample_en !== 1'h1 && k < 300);
        g = 0;
        do begin @(posedge clk); g++; end
        while (mod_sample_en !== 1'h1 && g < 300);
        #1;
    endtask
    task automatic pop;
        @(posedge clk);
        #1 res_ready = 1'h1;
        @(posedge clk);
        #1 res_ready = 1'h0;
        @(posedge clk);
        #1;
    endtask
    task results;
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {rst_n, clock_source_select_pin, clock_out_enable} = 3'h0;
        {clk_div_wr, clk_div_wdata, ref_buf_wr, ref_buf_wdata} = 4'h0;
        {start, mod_bit_ch1, mod_bit_ch2, res_ready} = 4'h4;
        data_rate_field = 3'h6;
        half = 2;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'h1;
        chk("divider after reset", 0, lead_off_status_register);
        chk("buffer after reset", 0, reference_buffer_power);
        for (k = 0; k < 4; k++)
        begin
            {clock_source_select_pin, clock_out_enable} = k[1:0];
            @(posedge clk);
            #1 chk("clock pin drive", k == 3, dev_clk_oe);
        end
        w[0] = dev_clk_out;
        repeat (8) @(posedge clk);
        #1 chk("oscillator toggles", !w[0], dev_clk_out);
        clock_source_select_pin = 1'h0;
        for (n = 1; n >= 0; n--)
        begin
            @(posedge clk);
            #1 ref_buf_wr = 1'h1;
            ref_buf_wdata = n[0];
            @(posedge clk);
            #1 ref_buf_wr = 1'h0;
            chk("reference buffer", n, reference_buffer_power);
        end
        set_div(1'h1);
        chk("fast clock strobe gap", 64, g);
        half = 8;
        set_div(1'h0);
        chk("slow clock strobe gap", 64, g);
        half = 2;
        // conversion: N is 32 at this data rate
        @(posedge clk);
        #1 start = 1'h1;
        n = 0;
        k = 0;
        do begin @(posedge clk); k++; n += mod_sample_en; end
        while (conversion_ready_n !== 1'h0 && k < 5000);
        #1 chk("settling not too early", 1, n >= 96);
        chk("settling bounded", 1, n <= 136);
        chk("deselected at ready", 1, cs_n);
        i_adcdp_host.read_frame(w);
        chk("clipped frame", 32'h7fff_8000, w);
        chk("ready released", 1, conversion_ready_n);
        k = 0;
        while (res_valid === 1'h1 && k < 20)
        begin
            pop();
            k++;
        end
        k = 0;
        do begin @(posedge clk); k++; end
        while (res_valid !== 1'h1 && k < 2000);
        // step the first channel just after a result, consumer stalls
        #1 mod_bit_ch1 = 1'h0;
        k = 0;
        while (res_overrun !== 1'h1 && k < 12000)
        begin
            @(posedge clk);
            k++;
        end
        #1;
        for (k = 0; k < 16; k++)
        begin
            w = res_data;
            if (k == 0)
                chk("before step", 32'h7fff_8000, w);
            else if (k == 1)
                chk("one period", 1, w[31:16] > 16'h5155 && w[31:16] < 16'h5955);
            else if (k == 2)
                chk("two periods", 1, w[31:16] > 16'ha6ab && w[31:16] < 16'haeab);
            else
                chk("settled step", 32'h8000_8000, w);
            pop();
        end
        chk("buffer drained", 0, res_valid);
        chk("overrun kept", 1, res_overrun);
        results();
    end
endmodule
